//--- hdl/krv_defs.svh
// Behaviour
// - Request pointer not 128-byte aligned or outside container range: protection fault.
// - Request page unmapped, invalid or blocked: page fault on request address.
// - Request page wrong type, owner, pending, modified, address or unreadable: page fault.
// - Output pointer not 16-byte aligned or outside container range: protection fault.
// - Output page unmapped, invalid or blocked: page fault on output address.
// - Output page wrong type, owner, pending, modified, address or unwritable: page fault.
// - Nonzero reserved request bits or reserved policy bits: protection fault.
// - Sealable attributes are (requested mask OR init/debug mask) AND container attributes.
// - Included misc value is requested misc mask AND container misc field.
// - Requested processor version above platform version (any key type but report): zero flag, version error, no key.
// - Requested software version above container version (any key type but report): zero flag, version error, exit.
// - Sealing key uses identity measurement only when policy identity bit is set.
// - Sealing key uses signer measurement only when policy signer bit is set.
// - Sealing key takes product, versions, key id, epoch, fuses, attributes, misc inputs.
// - Report key zeroes requested inputs except key id, uses full container values and fixed padding.
// - Launch-token key without launch capability: zero flag, attribute error, exit.
// - Launch-token key zeroes masks and measurements, takes epoch, fuses and requests.
// - Provisioning key without provisioning capability: zero flag, attribute error.
// - Success writes 128-bit key, result zero, zero flag cleared.
// - Unsupported key type: zero flag and bad key type error.
// - Carry, parity, aux-carry, overflow and sign flags cleared at every end without a fault.
// - An error ending leaves the output location untouched.
`ifndef KRV_DEFS_SVH
`define KRV_DEFS_SVH

`define KRV_REQ_ALIGN 7
`define KRV_OUT_ALIGN 4
`define KRV_REQ_LEN 65'h80
`define KRV_OUT_LEN 65'h10
`define KRV_PAGE_SHIFT 12
`define KRV_SEAL_MASK 128'h3
`define KRV_POL_IDENT 0
`define KRV_POL_SIGNER 1
`define KRV_ATTR_PROV 4
`define KRV_ATTR_LAUNCH 5

`define KRV_KT_LAUNCH 16'h0000
`define KRV_KT_PROV 16'h0001
`define KRV_KT_PROV_SEAL 16'h0002
`define KRV_KT_REPORT 16'h0003
`define KRV_KT_SEAL 16'h0004

`define KRV_ERR_NONE 32'h0000_0000
`define KRV_ERR_ATTR 32'h0000_0010
`define KRV_ERR_CPU_VER 32'h0000_0020
`define KRV_ERR_SW_VER 32'h0000_0040
`define KRV_ERR_KEY_TYPE 32'h0000_0080

`define KRV_REG_CTRL 8'h00
`define KRV_REG_STATUS 8'h04
`define KRV_REG_RESULT 8'h08
`define KRV_REG_FADDR_LO 8'h0c
`define KRV_REG_FADDR_HI 8'h10

`endif

//--- hdl/krv_pkg.sv
package krv_pkg;
    typedef enum logic [1:0] {
        KRV_IDLE = 2'b00,
        KRV_SEND = 2'b01,
        KRV_WAIT = 2'b10,
        KRV_WRITE = 2'b11
    } krv_state_t;

    typedef enum logic [1:0] {
        KRV_F_NONE = 2'b00,
        KRV_F_GP = 2'b01,
        KRV_F_PF_REQ = 2'b10,
        KRV_F_PF_OUT = 2'b11
    } krv_fault_t;

    typedef struct packed {
        logic in_mem;
        logic valid;
        logic blocked;
        logic regular;
        logic [63:0] owner;
        logic pending;
        logic modified;
        logic [51:0] lin_page;
        logic rd;
        logic wr;
    } krv_page_t;

    typedef struct packed {
        logic [63:0] base;
        logic [63:0] limit;
    } krv_range_t;

    typedef struct packed {
        logic [15:0] key_type;
        logic [15:0] policy;
        logic [255:0] key_id;
        logic [127:0] cpu_ver;
        logic [15:0] sw_ver;
        logic [127:0] attr_mask;
        logic [31:0] misc_mask;
        logic [63:0] rsvd;
    } krv_req_t;

    typedef struct packed {
        logic [63:0] id;
        logic [127:0] attr;
        logic [31:0] misc;
        logic [255:0] ident;
        logic [255:0] signer;
        logic [15:0] sw_ver;
        logic [15:0] prod_id;
    } krv_secs_t;

    typedef struct packed {
        logic [127:0] cpu_ver;
        logic [127:0] epoch;
        logic [127:0] fuses;
    } krv_plat_t;

    typedef struct packed {
        logic [15:0] key_type;
        logic [15:0] prod_id;
        logic [15:0] sw_ver;
        logic [127:0] epoch;
        logic [127:0] attr;
        logic [127:0] attr_mask;
        logic [255:0] ident;
        logic [255:0] signer;
        logic [255:0] key_id;
        logic [127:0] fuses;
        logic [127:0] cpu_ver;
        logic pad_fixed;
        logic [31:0] misc;
        logic [31:0] misc_mask;
    } krv_deriv_t;

    typedef struct packed {
        logic zf;
        logic cf;
        logic pf;
        logic af;
        logic of;
        logic sf;
    } krv_flags_t;

    typedef struct packed {
        krv_state_t state;
        logic done;
        krv_fault_t fault;
        logic [63:0] fault_addr;
        logic [31:0] result;
        krv_flags_t flags;
        krv_deriv_t drv;
        logic [63:0] out_addr;
        logic [127:0] key;
        logic [31:0] rdata;
    } krv_regs_t;
endpackage

//--- hdl/krv_key_request.sv
`timescale 1ns/1ps
`default_nettype none
`include "krv_defs.svh"

module krv_key_request (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [63:0] i_req_ptr,
    input wire logic [63:0] i_out_ptr,
    input wire krv_pkg::krv_range_t i_range,
    input wire krv_pkg::krv_req_t i_req,
    input wire krv_pkg::krv_page_t i_req_page,
    input wire krv_pkg::krv_page_t i_out_page,
    input wire krv_pkg::krv_secs_t i_secs,
    input wire krv_pkg::krv_plat_t i_plat,
    output logic o_drv_valid,
    input wire logic i_drv_ready,
    output krv_pkg::krv_deriv_t o_drv,
    input wire logic i_key_valid,
    input wire logic [127:0] i_key,
    output logic o_out_wr,
    output logic [63:0] o_out_addr,
    output logic [127:0] o_out_key,
    output krv_pkg::krv_fault_t o_fault,
    output krv_pkg::krv_flags_t o_flags,
    output logic [31:0] o_result,
    output logic o_busy,
    output logic o_done
);
    import krv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pointer checks shared by both operands

    function automatic logic outside_range(input logic [63:0] a,
                                           input logic [64:0] len,
                                           input krv_range_t r);
        logic [64:0] last;
        last = {1'b0, a} + len - 65'h1;
        outside_range = (a < r.base) || (last > {1'b0, r.limit});
    endfunction

    function automatic logic page_bad(input krv_page_t p,
                                      input logic [63:0] a,
                                      input logic [63:0] id,
                                      input logic need_wr);
        logic map_bad;
        logic attr_bad;
        map_bad = !p.in_mem || !p.valid || p.blocked;
        attr_bad = !p.regular || (p.owner != id) || p.pending ||
                   p.modified || (p.lin_page != a[63:`KRV_PAGE_SHIFT]) ||
                   (need_wr ? !p.wr : !p.rd);
        page_bad = map_bad || attr_bad;
    endfunction

    krv_regs_t st_ff;
    krv_regs_t nxt_st;

    logic go;
    logic req_gp;
    logic req_pf;
    logic out_gp;
    logic out_pf;
    logic rsv_gp;
    logic cpu_bad;
    logic sw_bad;
    logic [127:0] attr_seal;
    logic [31:0] misc_inc;
    logic [31:0] key_err;
    krv_deriv_t drv_asm;

    assign go = i_wr && (i_addr == `KRV_REG_CTRL) && i_wdata[0] &&
                (st_ff.state == KRV_IDLE);

    assign req_gp = (|i_req_ptr[`KRV_REQ_ALIGN-1:0]) ||
                    outside_range(i_req_ptr, `KRV_REQ_LEN, i_range);
    assign req_pf = page_bad(i_req_page, i_req_ptr, i_secs.id, 1'b0);
    assign out_gp = (|i_out_ptr[`KRV_OUT_ALIGN-1:0]) ||
                    outside_range(i_out_ptr, `KRV_OUT_LEN, i_range);
    assign out_pf = page_bad(i_out_page, i_out_ptr, i_secs.id, 1'b1);
    assign rsv_gp = (|i_req.rsvd) || (|i_req.policy[15:2]);

    assign attr_seal = (i_req.attr_mask | `KRV_SEAL_MASK) & i_secs.attr;
    assign misc_inc = i_req.misc_mask & i_secs.misc;
    assign cpu_bad = i_req.cpu_ver > i_plat.cpu_ver;
    assign sw_bad = i_req.sw_ver > i_secs.sw_ver;

    ////////////////////////////////////////////////////////////////////////
    // Per key type checks and derivation input selection

    always_comb begin
        drv_asm = '0;
        key_err = `KRV_ERR_NONE;
        drv_asm.key_type = i_req.key_type;
        drv_asm.prod_id = i_secs.prod_id;
        drv_asm.sw_ver = i_req.sw_ver;
        drv_asm.attr = attr_seal;
        drv_asm.attr_mask = i_req.attr_mask;
        drv_asm.cpu_ver = i_req.cpu_ver;
        drv_asm.misc = misc_inc;
        drv_asm.misc_mask = ~i_req.misc_mask;
        case (i_req.key_type)
            `KRV_KT_SEAL: begin
                if (cpu_bad) begin
                    key_err = `KRV_ERR_CPU_VER;
                end else if (sw_bad) begin
                    key_err = `KRV_ERR_SW_VER;
                end
                if (i_req.policy[`KRV_POL_IDENT]) begin
                    drv_asm.ident = i_secs.ident;
                end
                if (i_req.policy[`KRV_POL_SIGNER]) begin
                    drv_asm.signer = i_secs.signer;
                end
                drv_asm.epoch = i_plat.epoch;
                drv_asm.key_id = i_req.key_id;
                drv_asm.fuses = i_plat.fuses;
            end
            `KRV_KT_REPORT: begin
                drv_asm.prod_id = '0;
                drv_asm.sw_ver = '0;
                drv_asm.epoch = i_plat.epoch;
                drv_asm.attr = i_secs.attr;
                drv_asm.attr_mask = '0;
                drv_asm.ident = i_secs.ident;
                drv_asm.key_id = i_req.key_id;
                drv_asm.fuses = i_plat.fuses;
                drv_asm.cpu_ver = i_plat.cpu_ver;
                drv_asm.pad_fixed = 1'b1;
                drv_asm.misc = i_secs.misc;
                drv_asm.misc_mask = '0;
            end
            `KRV_KT_LAUNCH: begin
                if (!i_secs.attr[`KRV_ATTR_LAUNCH]) begin
                    key_err = `KRV_ERR_ATTR;
                end else if (cpu_bad) begin
                    key_err = `KRV_ERR_CPU_VER;
                end else if (sw_bad) begin
                    key_err = `KRV_ERR_SW_VER;
                end
                drv_asm.epoch = i_plat.epoch;
                drv_asm.attr_mask = '0;
                drv_asm.key_id = i_req.key_id;
                drv_asm.fuses = i_plat.fuses;
                drv_asm.misc_mask = '0;
            end
            `KRV_KT_PROV, `KRV_KT_PROV_SEAL: begin
                if (!i_secs.attr[`KRV_ATTR_PROV]) begin
                    key_err = `KRV_ERR_ATTR;
                end else if (cpu_bad) begin
                    key_err = `KRV_ERR_CPU_VER;
                end else if (sw_bad) begin
                    key_err = `KRV_ERR_SW_VER;
                end
                drv_asm.signer = i_secs.signer;
                if (i_req.key_type == `KRV_KT_PROV_SEAL) begin
                    drv_asm.fuses = i_plat.fuses;
                end
            end
            default: begin
                key_err = `KRV_ERR_KEY_TYPE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and register port

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff.state)
            KRV_IDLE: begin
                if (go) begin
                    nxt_st.done = 1'b0;
                    nxt_st.fault = KRV_F_NONE;
                    // Faults are precise: flags and result stay as they were
                    if (req_gp || out_gp || rsv_gp ||
                        req_pf || out_pf) begin
                        nxt_st.done = 1'b1;
                        nxt_st.fault_addr = '0;
                        if (req_gp) begin
                            nxt_st.fault = KRV_F_GP;
                        end else if (req_pf) begin
                            nxt_st.fault = KRV_F_PF_REQ;
                            nxt_st.fault_addr = i_req_ptr;
                        end else if (out_gp) begin
                            nxt_st.fault = KRV_F_GP;
                        end else if (out_pf) begin
                            nxt_st.fault = KRV_F_PF_OUT;
                            nxt_st.fault_addr = i_out_ptr;
                        end else begin
                            nxt_st.fault = KRV_F_GP;
                        end
                    end else if (key_err != `KRV_ERR_NONE) begin
                        nxt_st.done = 1'b1;
                        nxt_st.result = key_err;
                        nxt_st.flags = '0;
                        nxt_st.flags.zf = 1'b1;
                    end else begin
                        nxt_st.drv = drv_asm;
                        nxt_st.out_addr = i_out_ptr;
                        nxt_st.state = KRV_SEND;
                    end
                end
            end
            KRV_SEND: begin
                if (i_drv_ready) begin
                    nxt_st.state = KRV_WAIT;
                end
            end
            KRV_WAIT: begin
                if (i_key_valid) begin
                    nxt_st.key = i_key;
                    nxt_st.state = KRV_WRITE;
                end
            end
            KRV_WRITE: begin
                nxt_st.state = KRV_IDLE;
                nxt_st.done = 1'b1;
                nxt_st.result = `KRV_ERR_NONE;
                nxt_st.flags = '0;
            end
        endcase
        if (i_rd) begin
            case (i_addr)
                `KRV_REG_STATUS: nxt_st.rdata = {22'h0, st_ff.flags,
                    st_ff.fault, st_ff.done, st_ff.state != KRV_IDLE};
                `KRV_REG_RESULT: nxt_st.rdata = st_ff.result;
                `KRV_REG_FADDR_LO: nxt_st.rdata = st_ff.fault_addr[31:0];
                `KRV_REG_FADDR_HI: nxt_st.rdata = st_ff.fault_addr[63:32];
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata = st_ff.rdata;
    assign o_drv_valid = st_ff.state == KRV_SEND;
    assign o_drv = st_ff.drv;
    // Only the write state touches the output location
    assign o_out_wr = st_ff.state == KRV_WRITE;
    assign o_out_addr = st_ff.out_addr;
    assign o_out_key = st_ff.key;
    assign o_fault = st_ff.fault;
    assign o_flags = st_ff.flags;
    assign o_result = st_ff.result;
    assign o_busy = st_ff.state != KRV_IDLE;
    assign o_done = st_ff.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    req_align_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && (|i_req_ptr[6:0]) |=> o_done && o_fault == KRV_F_GP && !o_busy)
        else $error("misaligned request pointer not faulted");

    req_map_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && i_req_page.blocked
        |=> o_fault == KRV_F_PF_REQ && $past(i_req_ptr) == st_ff.fault_addr)
        else $error("blocked request page not faulted");

    req_page_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && (i_req_page.pending || !i_req_page.rd)
        |=> o_fault == KRV_F_PF_REQ)
        else $error("bad request page not faulted");

    out_align_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && !req_pf && (|i_out_ptr[3:0])
        |=> o_fault == KRV_F_GP)
        else $error("misaligned output pointer not faulted");

    out_page_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && !req_pf && !out_gp && !i_out_page.wr
        |=> o_fault == KRV_F_PF_OUT && !o_busy)
        else $error("read-only output page not faulted");

    rsv_field_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && !req_pf && !out_gp && !out_pf && (|i_req.rsvd)
        |=> o_fault == KRV_F_GP)
        else $error("reserved bits not faulted");

    seal_attr_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !o_busy ##1 o_drv_valid && o_drv.key_type == `KRV_KT_SEAL
        |-> o_drv.attr[1:0] == $past(i_secs.attr[1:0]))
        else $error("init and debug attributes dropped");

    launch_cap_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && !req_gp && !req_pf && !out_gp && !out_pf && !rsv_gp &&
        i_req.key_type == `KRV_KT_LAUNCH && !i_secs.attr[`KRV_ATTR_LAUNCH]
        |=> o_flags.zf && o_result == `KRV_ERR_ATTR && !o_busy)
        else $error("launch key granted without capability");

    ok_end_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        o_out_wr |=> o_done && !o_flags.zf && o_result == 32'h0)
        else $error("success not reported after key write");

    err_nowrite_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        go && key_err != `KRV_ERR_NONE && !req_gp && !req_pf && !out_gp
        && !out_pf && !rsv_gp |=> !o_out_wr [*2])
        else $error("output written after error");

    flags_clr_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b || !i_ce)
        $rose(o_done) && o_fault == KRV_F_NONE
        |-> !(o_flags.cf || o_flags.pf || o_flags.af || o_flags.of
              || o_flags.sf))
        else $error("arithmetic flags not cleared");
endmodule

`default_nettype wire

//--- verif/krv_drv_model.sv
`timescale 1ns/1ps
`default_nettype none

module krv_drv_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire krv_pkg::krv_deriv_t i_drv,
    input wire logic [1:0] i_lat,
    output logic o_ready,
    output logic o_key_valid,
    output logic [127:0] o_key
);
    import krv_pkg::*;
    ////////////////////////////////////////////////////////////////
    krv_deriv_t held;
    // Key bus toggles while idle so a stale key is never mistaken
    initial begin
        o_ready = 1'b0;
        o_key_valid = 1'b0;
        o_key = '0;
        forever begin
            @(posedge i_clk);
            o_key <= ~o_key;
            if (i_valid) begin
                repeat (i_lat) @(posedge i_clk);
                o_ready <= 1'b1;
                @(posedge i_clk);
                held = i_drv;
                o_ready <= 1'b0;
                repeat (i_lat) @(posedge i_clk);
                o_key_valid <= 1'b1;
                o_key <= held.key_id[127:0] ^ held.cpu_ver ^ held.attr;
                @(posedge i_clk);
                o_key_valid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import krv_pkg::*;
    ////////////////////////////////////////////////////////////////
    logic i_clk;
    logic i_rst_b = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic [63:0] i_req_ptr = '0;
    logic [63:0] i_out_ptr = '0;
    krv_range_t i_range = '0;
    krv_req_t i_req = '0;
    krv_page_t i_req_page = '0;
    krv_page_t i_out_page = '0;
    krv_secs_t i_secs = '0;
    krv_plat_t i_plat = '0;
    logic [1:0] lat = '0;
    logic [31:0] o_rdata, o_result;
    logic o_drv_valid, i_drv_ready, i_key_valid, o_out_wr, o_busy, o_done;
    logic [127:0] i_key, o_out_key;
    logic [63:0] o_out_addr;
    krv_deriv_t o_drv;
    krv_fault_t o_fault;
    krv_flags_t o_flags;
    int n_errors = 0;
    int num_checks = 0;
    krv_req_t s_rq;
    krv_page_t s_rp, s_op;
    krv_secs_t s_sc;
    krv_plat_t s_pl;
    krv_range_t s_rg;
    logic [63:0] s_ptr_r, s_ptr_o, e_fa;
    krv_fault_t e_fault;
    logic [31:0] e_res = '0;
    logic e_zf = 1'b0;
    krv_deriv_t e_drv;

    krv_key_request krv_key_request_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_req_ptr(i_req_ptr), .i_out_ptr(i_out_ptr), .i_range(i_range),
        .i_req(i_req), .i_req_page(i_req_page), .i_out_page(i_out_page),
        .i_secs(i_secs), .i_plat(i_plat), .o_drv_valid(o_drv_valid),
        .i_drv_ready(i_drv_ready), .o_drv(o_drv), .i_key_valid(i_key_valid),
        .i_key(i_key), .o_out_wr(o_out_wr), .o_out_addr(o_out_addr),
        .o_out_key(o_out_key), .o_fault(o_fault), .o_flags(o_flags),
        .o_result(o_result), .o_busy(o_busy), .o_done(o_done)
    );

    krv_drv_model krv_drv_model_i (
        .i_clk(i_clk), .i_valid(o_drv_valid), .i_drv(o_drv), .i_lat(lat),
        .o_ready(i_drv_ready), .o_key_valid(i_key_valid), .o_key(i_key)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_drv(krv_deriv_t e, krv_deriv_t g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] drv expected %h seen %h", e, g);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bus_wr(logic [7:0] a, logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic bus_rd(logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask

    function automatic logic [767:0] rnd();
        logic [767:0] v;
        for (int i = 0; i < 24; i++) v[i*32 +: 32] = $urandom;
        return v;
    endfunction

    function automatic logic in_rng(logic [63:0] p, logic [64:0] n);
        return p >= s_rg.base && {1'b0, p} + n - 65'h1 <= {1'b0, s_rg.limit};
    endfunction

    function automatic logic pg_bad(krv_page_t g, logic [63:0] p, logic w);
        return !g.in_mem || !g.valid || g.blocked || !g.regular ||
            g.owner != s_sc.id || g.pending || g.modified ||
            g.lin_page != p[63:12] || !(w ? g.wr : g.rd);
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic model();
        logic [15:0] kt;
        logic [127:0] sa;
        kt = s_rq.key_type;
        sa = (s_rq.attr_mask | 128'h3) & s_sc.attr;
        e_drv = '0;
        e_fa = '0;
        e_fault = KRV_F_GP;
        if (s_ptr_r[6:0] != 7'h0 || !in_rng(s_ptr_r, 65'h80)) begin
        end else if (pg_bad(s_rp, s_ptr_r, 1'b0)) begin
            e_fault = KRV_F_PF_REQ;
            e_fa = s_ptr_r;
        end else if (s_ptr_o[3:0] != 4'h0 || !in_rng(s_ptr_o, 65'h10)) begin
        end else if (pg_bad(s_op, s_ptr_o, 1'b1)) begin
            e_fault = KRV_F_PF_OUT;
            e_fa = s_ptr_o;
        end else if (s_rq.rsvd == '0 && s_rq.policy[15:2] == '0) begin
            e_fault = KRV_F_NONE;
            e_zf = 1'b1;
            if (kt > 16'h4) e_res = 32'h80;
            else if ((kt == 16'h0 && !s_sc.attr[5]) ||
                (kt inside {16'h1, 16'h2} && !s_sc.attr[4])) e_res = 32'h10;
            else if (kt != 16'h3 && s_rq.cpu_ver > s_pl.cpu_ver) e_res = 32'h20;
            else if (kt != 16'h3 && s_rq.sw_ver > s_sc.sw_ver) e_res = 32'h40;
            else begin
                e_res = '0;
                e_zf = 1'b0;
                e_drv = {kt, kt == 16'h3 ? 16'h0 : s_sc.prod_id,
                    kt == 16'h3 ? 16'h0 : s_rq.sw_ver,
                    kt inside {16'h1, 16'h2} ? 128'h0 : s_pl.epoch,
                    kt == 16'h3 ? s_sc.attr : sa,
                    kt inside {16'h0, 16'h3} ? 128'h0 : s_rq.attr_mask,
                    kt == 16'h3 || (kt == 16'h4 && s_rq.policy[0]) ?
                    s_sc.ident : 256'h0,
                    kt inside {16'h1, 16'h2} || (kt == 16'h4 && s_rq.policy[1])
                    ? s_sc.signer : 256'h0,
                    kt inside {16'h1, 16'h2} ? 256'h0 : s_rq.key_id,
                    kt == 16'h1 ? 128'h0 : s_pl.fuses,
                    kt == 16'h3 ? s_pl.cpu_ver : s_rq.cpu_ver, kt == 16'h3,
                    kt == 16'h3 ? s_sc.misc : s_rq.misc_mask & s_sc.misc,
                    kt inside {16'h0, 16'h3} ? 32'h0 : ~s_rq.misc_mask};
            end
        end
    endtask

    task automatic run_case(int k);
        logic [767:0] v;
        logic [31:0] d;
        int n;
        int nw;
        v = rnd();
        s_sc = v;
        v = rnd();
        s_rq = v[$bits(krv_req_t)-1:0];
        v = rnd();
        s_pl = v[$bits(krv_plat_t)-1:0];
        s_ptr_r = 64'h1000_0000 | {43'h0, v[720:707], 7'h0};
        s_ptr_o = 64'h1000_0000 | {36'h0, v[700:677], 4'h0};
        s_rg = {64'h1000_0000, 64'h1fff_ffff};
        s_pl.cpu_ver[127] = 1'b0;
        s_sc.sw_ver[15] = 1'b0;
        s_sc.attr[5:4] = 2'b11;
        s_rq.cpu_ver = s_pl.cpu_ver;
        s_rq.sw_ver = s_sc.sw_ver;
        s_rq.rsvd = '0;
        s_rq.policy = {14'h0, 2'(k)};
        s_rq.key_type = 16'h4;
        s_rp = {4'b1101, s_sc.id, 2'b00, s_ptr_r[63:12], 2'b11};
        s_op = {4'b1101, s_sc.id, 2'b00, s_ptr_o[63:12], 2'b11};
        case (k)
            1: s_rq.key_type = 16'h3;
            2: {s_rq.key_type, s_sc.attr[5]} = {16'h0, 1'b0};
            3: s_rq.key_type = 16'h0;
            4: {s_rq.key_type, s_sc.attr[4]} = {16'h1, 1'b0};
            5: s_rq.key_type = 16'h2;
            6: s_rq.key_type = 16'h1;
            7: s_rq.cpu_ver = s_pl.cpu_ver + 128'h1;
            8: s_rq.sw_ver = s_sc.sw_ver + 16'h1;
            9: s_rq.key_type = 16'h5;
            10: s_ptr_r[6] = 1'b1;
            11: s_rp.blocked = 1'b1;
            12: s_rp.rd = 1'b0;
            13: s_ptr_o[3] = 1'b1;
            14: s_op.valid = 1'b0;
            15: s_op.wr = 1'b0;
            16: {s_rq.rsvd[63], s_rq.key_type} = {1'b1, 16'h5};
            17: s_rq.policy[5] = 1'b1;
            18: s_ptr_o = 64'h2000_0000;
            19: s_op.owner = ~s_sc.id;
            20: s_ptr_r = 64'h0fff_ff80;
            21: s_op.lin_page = '0;
            default: ;
        endcase
        model();
        i_req_ptr <= s_ptr_r;
        i_out_ptr <= s_ptr_o;
        i_range <= s_rg;
        i_req <= s_rq;
        i_req_page <= s_rp;
        i_out_page <= s_op;
        i_secs <= s_sc;
        i_plat <= s_pl;
        lat <= 2'(k % 3);
        bus_wr(8'h00, 32'h1);
        n = 0;
        nw = 0;
        do begin
            @(posedge i_clk);
            n++;
            if (o_drv_valid === 1'b1) chk_drv(e_drv, o_drv);
            if (o_out_wr === 1'b1) begin
                nw++;
                chk("out_addr", s_ptr_o, o_out_addr);
                chk("out_key", e_drv.key_id[127:0] ^ e_drv.cpu_ver ^ e_drv.attr, o_out_key);
            end
        end while (o_done !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            $display("[FAIL] done expected 1 seen 0");
            finish_test();
        end
        chk("out_writes", 128'(e_fault == KRV_F_NONE && e_res == '0), 128'(nw));
        chk("result_port", e_res, o_result);
        chk("flags_fault", {e_zf, 5'h0, e_fault}, {o_flags, o_fault});
        bus_rd(8'h04, d);
        chk("status", {22'h0, e_zf, 5'h0, e_fault, 2'b10}, d);
        bus_rd(8'h08, d);
        chk("result", e_res, d);
        if (e_fault != KRV_F_NONE) begin
            bus_rd(8'h0c, d);
            chk("faddr_lo", e_fa[31:0], d);
            bus_rd(8'h10, d);
            chk("faddr_hi", e_fa[63:32], d);
        end
        bus_rd(8'h20, d);
        chk("unmapped", '0, d);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        void'($urandom(32'h197f));
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        bus_rd(8'h04, d);
        chk("status_rst", '0, d);
        for (int k = 0; k < 24; k++) run_case(k);
        finish_test();
    end
endmodule

`default_nettype wire
